// *** rtl/modem_tlv_end.sv ***
module modem_tlv_end
	import tlv_codec_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	tlv_link_if.modem_end link,
	input wire logic start,
	input wire msg_kind_e kind,
	input wire logic concat_req,
	input wire logic frag_req,
	input wire logic phs_req,
	input wire logic [7:0] version,
	input wire logic [7:0] privacy_level,
	input wire logic [7:0] ds_sa_count,
	input wire logic [7:0] us_sid_count,
	input wire logic [7:0] taps_per_sym,
	input wire logic [7:0] eq_taps,
	input wire logic dcc_support,
	input wire logic mcast_support,
	input wire logic [1:0] filter_bits,
	input wire logic [47:0] mac_addr,
	input wire logic [3:0] key_seq,
	input wire logic privacy_en,
	input wire logic auth_en,
	input wire logic [2:0] auth_len,
	input wire logic [31:0] auth_bytes,
	input wire logic [159:0] digest,
	input wire logic digest_valid,
	output logic busy,
	output logic [7:0] hash_data,
	output logic hash_valid,
	output logic rsp_done,
	output logic rsp_failed,
	output logic rsp_concat,
	output logic rsp_frag,
	output logic rsp_phs
);
	////////////////////////////////////////////////////////////////////////
	// frame composition
	logic [7:0] sub_val [0:NUM_SUBS-1];
	logic [NUM_SUBS-1:0] sub_on;
	logic [7:0] fb [0:MAX_BYTES-1];
	logic [5:0] flen_d, dig_d;
	wire logic is_caps = kind == K_REG_REQ || kind == K_DHCP;
	wire logic is_dhcp = kind == K_DHCP;
	wire logic [2:0] auth_n = (auth_len > 3'(AUTH_MAX)) ? 3'(AUTH_MAX) :
		auth_len;

	// bit s stands for subtype s+1
	assign sub_on = {is_caps, is_caps & eq_taps != 8'h00,
		is_caps & taps_per_sym != 8'h00, is_dhcp,
		is_caps, is_caps, is_caps, is_dhcp, is_caps, is_caps,
		is_caps, is_caps};
	assign sub_val[0] = {7'h00, concat_req};
	assign sub_val[1] = version;
	assign sub_val[2] = {7'h00, frag_req};
	assign sub_val[3] = {7'h00, phs_req};
	assign sub_val[4] = {7'h00, mcast_support};
	assign sub_val[5] = privacy_level;
	assign sub_val[6] = ds_sa_count;
	assign sub_val[7] = us_sid_count;
	assign sub_val[8] = {6'h00, filter_bits};
	assign sub_val[9] = taps_per_sym;
	assign sub_val[10] = eq_taps;
	assign sub_val[11] = {7'h00, dcc_support};

	always_comb begin
		int p;
		p = 0;
		dig_d = 6'h3F;
		for (int i = 0; i < MAX_BYTES; i++)
			fb[i] = 8'h00;
		if (is_caps) begin
			fb[0] = T_CAPS;
			p = 2;
			for (int s = 0; s < NUM_SUBS; s++) begin
				if (sub_on[s]) begin
					fb[p] = 8'(s + 1);
					fb[p + 1] = LEN_ONE;
					fb[p + 2] = sub_val[s];
					p = p + 3;
				end
			end
			fb[1] = 8'(p - 2);
		end
		if (kind == K_REG_REQ) begin
			fb[p] = T_VENDOR;
			fb[p + 1] = LEN_VENDOR;
			fb[p + 2] = mac_addr[47:40];
			fb[p + 3] = mac_addr[39:32];
			fb[p + 4] = mac_addr[31:24];
			p = p + 5;
		end
		if (!is_caps) begin
			if (auth_en) begin
				fb[p] = T_AUTH;
				fb[p + 1] = {5'h00, auth_n};
				for (int j = 0; j < AUTH_MAX; j++)
					if (3'(j) < auth_n)
						fb[p + 2 + j] = auth_bytes[31 - 8 * j -: 8];
				p = p + 2 + int'(auth_n);
			end
			fb[p] = T_KEY_SEQ;
			fb[p + 1] = LEN_ONE;
			fb[p + 2] = {4'h0, key_seq};
			p = p + 3;
			if (privacy_en) begin
				fb[p] = T_DIGEST;
				fb[p + 1] = LEN_DIGEST;
				dig_d = 6'(p + 2);
				p = p + 22;
			end
		end
		flen_d = 6'(p);
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	logic [7:0] mem_q [0:MAX_BYTES-1];
	logic [5:0] flen_q, dig_q, idx_q;
	msg_kind_e kind_q;
	send_st_e st_q;
	logic [8:0] ent_q [0:1];
	logic [1:0] cnt_q;
	wire logic in_dig = idx_q >= dig_q;
	wire logic [4:0] dig_k = 5'(idx_q - dig_q);
	wire logic [7:0] dig_byte = 8'(digest >> {5'(5'd19 - dig_k), 3'b000});
	wire logic [7:0] cur = in_dig ? dig_byte : mem_q[idx_q];
	wire logic buf_ready = cnt_q != 2'd2;
	wire logic stall = in_dig & ~digest_valid;
	wire logic push = st_q == ST_SEND & ~stall & buf_ready;
	wire logic push_last = idx_q == 6'(flen_q - 6'd1);
	wire logic pop = link.up_valid & link.up_ready;
	wire logic wr_i = cnt_q[0] & ~pop;
	wire logic dyn_q = kind_q == K_SVC_ADD_REQ || kind_q == K_SVC_CHG_REQ;

	assign busy = st_q == ST_SEND || cnt_q != 2'd0;
	assign link.up_valid = cnt_q != 2'd0;
	assign link.up_data = ent_q[0][7:0];
	assign link.up_last = ent_q[0][8];
	assign link.up_kind = kind_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			idx_q <= 6'd0;
			flen_q <= 6'd0;
			dig_q <= 6'h3F;
			kind_q <= K_REG_REQ;
			mem_q <= '{default: 8'h00};
		end else if (st_q == ST_IDLE) begin
			if (start & ~busy) begin
				st_q <= ST_SEND;
				idx_q <= 6'd0;
				flen_q <= flen_d;
				dig_q <= dig_d;
				kind_q <= kind;
				mem_q <= fb;
			end
		end else if (push) begin
			idx_q <= 6'(idx_q + 6'd1);
			if (push_last)
				st_q <= ST_IDLE;
		end
	end

	// two-entry buffer in front of the link
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ent_q[0] <= 9'h000;
			ent_q[1] <= 9'h000;
			cnt_q <= 2'd0;
		end else begin
			if (pop)
				ent_q[0] <= ent_q[1];
			if (push)
				ent_q[wr_i] <= {push_last, cur};
			cnt_q <= 2'(cnt_q + 2'(push) - 2'(pop));
		end
	end

	// in service add and change requests, bytes ahead of the digest element feed the hash engine
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hash_valid <= 1'b0;
			hash_data <= 8'h00;
		end else begin
			hash_valid <= push & dyn_q & idx_q < 6'(dig_q - 6'd2);
			hash_data <= cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// response parser
	parse_ph_e oph_q, sph_q, oph_d, sph_d;
	logic [7:0] otype_q, orem_q, stype_q, srem_q;
	logic acc_fail_q, acc_concat_q, acc_frag_q, acc_phs_q;
	wire logic [7:0] d = link.dn_data;
	wire logic take = link.dn_valid & link.dn_ready;
	wire logic t_last = take & link.dn_last;
	wire logic o_val = take & oph_q == PH_VAL;
	wire logic in_caps = o_val & otype_q == T_CAPS;
	wire logic sub_b = in_caps & sph_q == PH_VAL;
	wire logic fail_d = acc_fail_q | (o_val & otype_q == T_NO_SERVICE);
	wire logic concat_d = (sub_b & stype_q == SUB_CONCAT) ? d[0] :
		acc_concat_q;
	wire logic frag_d = (sub_b & stype_q == SUB_FRAG) ? d[0] : acc_frag_q;
	wire logic phs_d = (sub_b & stype_q == SUB_PHS) ? d[0] : acc_phs_q;

	assign link.dn_ready = 1'b1;
	assign oph_d = t_last ? PH_TYPE : take ? ph_next(oph_q, d, orem_q) :
		oph_q;
	assign sph_d = ((take & oph_q == PH_LEN) | t_last) ? PH_TYPE :
		in_caps ? ph_next(sph_q, d, srem_q) : sph_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oph_q <= PH_TYPE;
			sph_q <= PH_TYPE;
			orem_q <= 8'h00;
			srem_q <= 8'h00;
			otype_q <= 8'h00;
			stype_q <= 8'h00;
		end else begin
			oph_q <= oph_d;
			sph_q <= sph_d;
			orem_q <= take ? rem_next(oph_q, d, orem_q) : orem_q;
			srem_q <= in_caps ? rem_next(sph_q, d, srem_q) : srem_q;
			if (take & oph_q == PH_TYPE)
				otype_q <= d;
			if (in_caps & sph_q == PH_TYPE)
				stype_q <= d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{acc_fail_q, acc_concat_q, acc_frag_q, acc_phs_q} <= 4'h0;
			{rsp_failed, rsp_concat, rsp_frag, rsp_phs} <= 4'h0;
			rsp_done <= 1'b0;
		end else begin
			rsp_done <= t_last;
			if (t_last) begin
				{acc_fail_q, acc_concat_q, acc_frag_q, acc_phs_q} <= 4'h0;
				rsp_failed <= fail_d;
				rsp_concat <= concat_d & ~fail_d;
				rsp_frag <= frag_d & ~fail_d;
				rsp_phs <= phs_d & ~fail_d;
			end else begin
				acc_fail_q <= fail_d;
				acc_concat_q <= concat_d;
				acc_frag_q <= frag_d;
				acc_phs_q <= phs_d;
			end
		end
	end
endmodule // modem_tlv_end

// *** common/tlv_codec_pkg.sv ***
package tlv_codec_pkg;
	localparam int MAX_BYTES = 40;
	localparam int RSP_BYTES = 24;
	localparam int NUM_SUBS = 12;
	localparam int AUTH_MAX = 4;
	localparam logic [7:0] T_CAPS = 8'h05;
	localparam logic [7:0] T_VENDOR = 8'h08;
	localparam logic [7:0] T_NO_SERVICE = 8'h0D;
	localparam logic [7:0] T_DIGEST = 8'h1B;
	localparam logic [7:0] T_AUTH = 8'h1E;
	localparam logic [7:0] T_KEY_SEQ = 8'h1F;
	localparam logic [7:0] SUB_CONCAT = 8'h01;
	localparam logic [7:0] SUB_FRAG = 8'h03;
	localparam logic [7:0] SUB_PHS = 8'h04;
	localparam logic [7:0] LEN_ONE = 8'h01;
	localparam logic [7:0] LEN_VENDOR = 8'h03;
	localparam logic [7:0] LEN_NO_SERVICE = 8'h03;
	localparam logic [7:0] LEN_DIGEST = 8'h14;
	localparam logic [7:0] KEY_SEQ_MAX = 8'h0F;
	localparam logic [7:0] VERSION_BASE = 8'h00;
	localparam logic [7:0] DEF_TAPS_PER_SYM = 8'h01;
	localparam logic [7:0] DEF_EQ_TAPS = 8'h08;
	// subtypes echoed in a response, and those answered by grant
	localparam logic [NUM_SUBS-1:0] RSP_MASK = 12'h11D;
	localparam logic [NUM_SUBS-1:0] GRANT_MASK = 12'h00D;

	typedef enum logic [1:0] {
		K_REG_REQ,
		K_DHCP,
		K_SVC_ADD_REQ,
		K_SVC_CHG_REQ
	} msg_kind_e;
	typedef enum logic [1:0] {PH_TYPE, PH_LEN, PH_VAL} parse_ph_e;
	typedef enum logic {ST_IDLE, ST_SEND} send_st_e;

	function automatic parse_ph_e ph_next(parse_ph_e ph, logic [7:0] d,
		logic [7:0] rem);
		case (ph)
		PH_TYPE: return PH_LEN;
		PH_LEN: return (d == 8'h00) ? PH_TYPE : PH_VAL;
		PH_VAL: return (rem == 8'h01) ? PH_TYPE : PH_VAL;
		default: return PH_TYPE;
		endcase
	endfunction

	function automatic logic [7:0] rem_next(parse_ph_e ph, logic [7:0] d,
		logic [7:0] rem);
		case (ph)
		PH_LEN: return d;
		PH_VAL: return rem - 8'h01;
		default: return rem;
		endcase
	endfunction

	function automatic logic [7:0] at_least_one(logic [7:0] v);
		return (v == 8'h00) ? 8'h01 : v;
	endfunction
endpackage

// *** common/tlv_link_if.sv ***
interface tlv_link_if;
	import tlv_codec_pkg::*;
	logic up_valid;
	logic up_ready;
	logic [7:0] up_data;
	logic up_last;
	msg_kind_e up_kind;
	logic dn_valid;
	logic dn_ready;
	logic [7:0] dn_data;
	logic dn_last;
	modport modem_end (output up_valid, up_data, up_last, up_kind,
		input up_ready, input dn_valid, dn_data, dn_last, output dn_ready);
	modport headend_end (input up_valid, up_data, up_last, up_kind,
		output up_ready, output dn_valid, dn_data, dn_last, input dn_ready);
endinterface

// *** rtl/headend_tlv_end.sv ***
module headend_tlv_end
	import tlv_codec_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	tlv_link_if.headend_end link,
	input wire logic privacy_en,
	output logic msg_done,
	output msg_kind_e msg_kind,
	output logic [7:0] caps [0:NUM_SUBS-1],
	output logic [NUM_SUBS-1:0] caps_seen,
	output logic [7:0] version,
	output logic [7:0] ds_sa_count,
	output logic [7:0] us_sid_count,
	output logic [7:0] taps_per_sym,
	output logic [7:0] eq_taps,
	output logic [23:0] vendor_oui,
	output logic [7:0] key_seq,
	output logic key_seq_bad,
	output logic [7:0] auth_data,
	output logic auth_valid,
	output logic auth_error,
	output logic [159:0] digest,
	output logic digest_error,
	output logic [7:0] hash_data,
	output logic hash_valid,
	input wire logic rsp_start,
	input wire logic grant_concat,
	input wire logic grant_frag,
	input wire logic grant_phs,
	input wire logic refuse,
	input wire logic [7:0] class_id,
	input wire logic [7:0] obj_type,
	input wire logic [7:0] conf_code,
	output logic rsp_busy
);
	////////////////////////////////////////////////////////////////////////
	// request parser
	parse_ph_e oph_q, sph_q, oph_d, sph_d;
	logic [7:0] otype_q, orem_q, stype_q, srem_q;
	logic open_q, dig_seen_q, last_q;
	logic [1:0] auth_cnt_q;
	wire logic [7:0] d = link.up_data;
	wire logic take = link.up_valid & link.up_ready;
	wire logic first = take & ~open_q;
	wire logic is_type = take & oph_q == PH_TYPE;
	wire logic o_val = take & oph_q == PH_VAL;
	wire logic in_caps = o_val & otype_q == T_CAPS;
	wire logic sub_val = in_caps & sph_q == PH_VAL;
	wire logic sub_ok = stype_q != 8'h00 && stype_q <= 8'(NUM_SUBS);
	wire logic [3:0] sub_i = 4'(stype_q - 8'h01);
	wire logic is_dyn = link.up_kind == K_SVC_ADD_REQ ||
		link.up_kind == K_SVC_CHG_REQ;
	wire logic dig_start = is_type & d == T_DIGEST;
	wire logic in_dig = dig_seen_q & ~first;
	wire logic dig_bad_now = (is_type & in_dig) |
		(take & oph_q == PH_LEN & otype_q == T_DIGEST & d != LEN_DIGEST) |
		(take & link.up_last & privacy_en & is_dyn & ~in_dig & ~dig_start);
	wire logic auth_bad_now = is_type & d == T_AUTH &
		(~is_dyn | (auth_cnt_q != 2'd0 & ~first));

	assign link.up_ready = 1'b1;
	assign oph_d = (take & link.up_last) ? PH_TYPE :
		take ? ph_next(oph_q, d, orem_q) : oph_q;
	assign sph_d = ((take & oph_q == PH_LEN) | (take & link.up_last)) ?
		PH_TYPE : in_caps ? ph_next(sph_q, d, srem_q) : sph_q;
	// missing subtypes fall back to their implied values
	assign version = caps_seen[1] ? caps[1] : VERSION_BASE;
	assign ds_sa_count = at_least_one(caps[6]);
	assign us_sid_count = at_least_one(caps[7]);
	assign taps_per_sym = caps_seen[9] ? caps[9] : DEF_TAPS_PER_SYM;
	assign eq_taps = caps_seen[10] ? caps[10] : DEF_EQ_TAPS;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oph_q <= PH_TYPE;
			sph_q <= PH_TYPE;
			orem_q <= 8'h00;
			srem_q <= 8'h00;
		end else begin
			oph_q <= oph_d;
			sph_q <= sph_d;
			orem_q <= take ? rem_next(oph_q, d, orem_q) : orem_q;
			srem_q <= in_caps ? rem_next(sph_q, d, srem_q) : srem_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			otype_q <= 8'h00;
			stype_q <= 8'h00;
			open_q <= 1'b0;
			msg_done <= 1'b0;
			msg_kind <= K_REG_REQ;
		end else begin
			if (is_type)
				otype_q <= d;
			if (in_caps & sph_q == PH_TYPE)
				stype_q <= d;
			if (take)
				open_q <= ~link.up_last;
			if (first)
				msg_kind <= link.up_kind;
			msg_done <= take & link.up_last;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			caps <= '{default: 8'h00};
			caps_seen <= '0;
		end else if (first) begin
			caps <= '{default: 8'h00};
			caps_seen <= '0;
		end else if (sub_val & sub_ok) begin
			caps[sub_i] <= d;
			caps_seen[sub_i] <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vendor_oui <= 24'h000000;
			key_seq <= 8'h00;
			key_seq_bad <= 1'b0;
			auth_cnt_q <= 2'd0;
			auth_error <= 1'b0;
			auth_valid <= 1'b0;
			auth_data <= 8'h00;
			digest <= '0;
			dig_seen_q <= 1'b0;
			digest_error <= 1'b0;
			hash_valid <= 1'b0;
			hash_data <= 8'h00;
		end else begin
			if (o_val & otype_q == T_VENDOR)
				vendor_oui <= {vendor_oui[15:0], d};
			if (o_val & otype_q == T_KEY_SEQ) begin
				key_seq <= d;
				key_seq_bad <= d > KEY_SEQ_MAX;
			end
			if (is_type & d == T_AUTH)
				auth_cnt_q <= first ? 2'd1 : 2'd2;
			else if (first)
				auth_cnt_q <= 2'd0;
			auth_error <= (auth_error & ~first) | auth_bad_now;
			auth_valid <= o_val & otype_q == T_AUTH;
			auth_data <= d;
			if (o_val & otype_q == T_DIGEST)
				digest <= {digest[151:0], d};
			dig_seen_q <= dig_start | in_dig;
			if (take)
				digest_error <= (digest_error & ~first) | dig_bad_now;
			hash_valid <= take & is_dyn & ~in_dig & ~dig_start;
			hash_data <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registration response builder
	logic [7:0] fb [0:RSP_BYTES-1];
	logic [7:0] mem_q [0:RSP_BYTES-1];
	logic [4:0] flen_d, flen_q, idx_q;
	send_st_e st_q;
	wire logic [NUM_SUBS-1:0] grant = {8'h00, grant_phs, grant_frag, 1'b0,
		grant_concat};
	wire logic pop = link.dn_valid & link.dn_ready;
	wire logic pop_last = idx_q == 5'(flen_q - 5'd1);

	always_comb begin
		int p;
		p = 2;
		for (int i = 0; i < RSP_BYTES; i++)
			fb[i] = 8'h00;
		fb[0] = T_CAPS;
		for (int s = 0; s < NUM_SUBS; s++) begin
			if (caps_seen[s] && RSP_MASK[s]) begin
				fb[p] = 8'(s + 1);
				fb[p + 1] = LEN_ONE;
				fb[p + 2] = GRANT_MASK[s] ?
					{7'h00, caps[s][0] & grant[s]} : caps[s];
				p = p + 3;
			end
		end
		fb[1] = 8'(p - 2);
		if (refuse) begin
			fb[p] = T_NO_SERVICE;
			fb[p + 1] = LEN_NO_SERVICE;
			fb[p + 2] = class_id;
			fb[p + 3] = obj_type;
			fb[p + 4] = conf_code;
			p = p + 5;
		end
		flen_d = 5'(p);
	end

	assign rsp_busy = st_q == ST_SEND;
	assign link.dn_valid = st_q == ST_SEND;
	assign link.dn_data = mem_q[idx_q];
	assign link.dn_last = pop_last;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			idx_q <= 5'd0;
			flen_q <= 5'd0;
			mem_q <= '{default: 8'h00};
		end else if (st_q == ST_IDLE) begin
			if (rsp_start) begin
				st_q <= ST_SEND;
				idx_q <= 5'd0;
				flen_q <= flen_d;
				mem_q <= fb;
			end
		end else if (pop) begin
			idx_q <= 5'(idx_q + 5'd1);
			if (pop_last)
				st_q <= ST_IDLE;
		end
	end
endmodule // headend_tlv_end

// *** sim/tlv_link_properties.sv ***
module tlv_link_properties
	import tlv_codec_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic up_valid,
	input wire logic up_ready,
	input wire logic [7:0] up_data,
	input wire logic up_last,
	input wire msg_kind_e up_kind,
	input wire logic dn_valid,
	input wire logic dn_ready,
	input wire logic [7:0] dn_data,
	input wire logic dn_last
);
	timeunit 1ns;
	timeprecision 100ps;
	// element tracker: phase 0 type, 1 length, 2 value
	logic [1:0] ph_q, ph_d, sub_q, sub_d;
	logic [7:0] typ_q, typ_d, rem_q, rem_d;
	logic first_q, first_d, dfirst_q, dfirst_d;
	wire logic up_xfer = up_valid && up_ready;
	wire logic dn_xfer = dn_valid && dn_ready;
	wire logic in_caps = ph_q == 2'd2 && typ_q == T_CAPS;
	wire logic dyn_kind = up_kind == K_SVC_ADD_REQ ||
		up_kind == K_SVC_CHG_REQ;
	wire logic [1:0] ph_len = up_data == 8'h00 ? 2'd0 : 2'd2;
	wire logic [1:0] ph_val = rem_q == 8'h01 ? 2'd0 : 2'd2;
	wire logic [1:0] ph_adv = ph_q == 2'd0 ? 2'd1 :
		ph_q == 2'd1 ? ph_len : ph_val;
	wire logic [1:0] sub_adv = sub_q == 2'd2 ? 2'd0 : sub_q + 2'd1;
	assign ph_d = !up_xfer ? ph_q : up_last ? 2'd0 : ph_adv;
	assign typ_d = up_xfer && ph_q == 2'd0 ? up_data : typ_q;
	assign rem_d = !up_xfer ? rem_q : ph_q == 2'd1 ? up_data : rem_q - 8'h01;
	assign sub_d = !up_xfer ? sub_q : ph_q == 2'd1 ? 2'd0 :
		ph_q == 2'd2 ? sub_adv : sub_q;
	assign first_d = up_xfer ? up_last : first_q;
	assign dfirst_d = dn_xfer ? dn_last : dfirst_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_q <= 2'd0;
			sub_q <= 2'd0;
			typ_q <= 8'h00;
			rem_q <= 8'h00;
			first_q <= 1'b1;
			dfirst_q <= 1'b1;
		end else begin
			ph_q <= ph_d;
			sub_q <= sub_d;
			typ_q <= typ_d;
			rem_q <= rem_d;
			first_q <= first_d;
			dfirst_q <= dfirst_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_FIRST_CAPS: assert property (up_valid && first_q && !dyn_kind
		|-> up_data == T_CAPS) else $error("request does not open with caps");
	AST_FIRST_DYN: assert property (up_valid && first_q && dyn_kind
		|-> up_data == T_AUTH || up_data == T_KEY_SEQ)
		else $error("dynamic message opens wrongly");
	AST_SUB_LEN: assert property (up_valid && in_caps && sub_q == 2'd1
		|-> up_data == LEN_ONE) else $error("capability length not one");
	AST_REG_NO_UNNEG: assert property (up_valid && in_caps && sub_q == 2'd0
		&& up_kind == K_REG_REQ |-> up_data != 8'h05 && up_data != 8'h09)
		else $error("unnegotiated capability in registration");
	AST_VENDOR_NEXT: assert property (up_valid && !first_q && ph_q == 2'd0
		&& up_kind == K_REG_REQ |-> up_data == T_VENDOR)
		else $error("registration lacks vendor element");
	AST_VENDOR_LEN: assert property (up_valid && ph_q == 2'd1
		&& typ_q == T_VENDOR |-> up_data == LEN_VENDOR)
		else $error("vendor length wrong");
	AST_KEY_RANGE: assert property (up_valid && ph_q == 2'd2
		&& typ_q == T_KEY_SEQ |-> up_data <= KEY_SEQ_MAX && rem_q == 8'h01)
		else $error("key sequence out of range");
	AST_DIGEST_LEN: assert property (up_valid && ph_q == 2'd1
		&& typ_q == T_DIGEST |-> up_data == LEN_DIGEST)
		else $error("digest length wrong");
	AST_DIGEST_END: assert property (up_valid && ph_q == 2'd2
		&& typ_q == T_DIGEST |-> up_last == (rem_q == 8'h01))
		else $error("digest not final element");
	AST_LAST_ALIGN: assert property (up_valid && up_last
		|-> ph_q == 2'd2 && rem_q == 8'h01 || ph_q == 2'd1 && up_data == 8'h00)
		else $error("message ends inside an element");
	AST_KIND_STEADY: assert property (up_valid && !first_q
		|-> $stable(up_kind)) else $error("kind changed in message");
	AST_DN_OPEN: assert property (dn_valid && dfirst_q
		|-> dn_data == T_CAPS) else $error("response does not open with caps");

	COV_REG: cover property (up_xfer && up_last && up_kind == K_REG_REQ);
	COV_DHCP: cover property (up_xfer && up_last && up_kind == K_DHCP);
	COV_DIGEST: cover property (up_xfer && up_last && typ_q == T_DIGEST);
	COV_RSP: cover property (dn_xfer && dn_last);
endmodule // tlv_link_properties

// *** sim/modem_capability_tlv_codec_tb.sv ***
module modem_capability_tlv_codec_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import tlv_codec_pkg::*;
	typedef struct packed {
		msg_kind_e kind;
		logic [2:0] req, grant;
		logic refuse, zero;
		logic [11:0] seen;
		logic [2:0] rsp;
	} row_s;
	localparam row_s ROWS [6] = '{
		'{K_REG_REQ, 3'b111, 3'b111, 1'b0, 1'b0, 12'hEEF, 3'b111},
		'{K_REG_REQ, 3'b101, 3'b011, 1'b0, 1'b1, 12'h8EF, 3'b001},
		'{K_REG_REQ, 3'b111, 3'b111, 1'b1, 1'b0, 12'hEEF, 3'b000},
		'{K_DHCP, 3'b010, 3'b000, 1'b0, 1'b0, 12'hFFF, 3'b000},
		'{K_SVC_ADD_REQ, 3'b000, 3'b000, 1'b0, 1'b0, 12'h000, 3'b000},
		'{K_SVC_CHG_REQ, 3'b000, 3'b000, 1'b0, 1'b1, 12'h000, 3'b000}};
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, rsp_start = 1'b0;
	msg_kind_e kind = K_REG_REQ, got_kind;
	logic concat_req = 0, frag_req = 0, phs_req = 0, dcc_support = 0;
	logic mcast_support = 0, auth_en = 1, privacy_en = 1, digest_valid = 1;
	logic [7:0] version = 0, privacy_level = 0, ds_sa_count = 0;
	logic [7:0] us_sid_count = 0, taps_per_sym = 0, eq_taps = 0;
	logic [1:0] filter_bits = 0;
	logic [47:0] mac_addr = 0;
	logic [3:0] key_seq = 0;
	logic [2:0] auth_len = 0;
	logic [31:0] auth_bytes = 0, ash = 0;
	logic [159:0] digest = 0, dig;
	logic grant_concat = 0, grant_frag = 0, grant_phs = 0, refuse = 0;
	logic [7:0] class_id = 8'h21, obj_type = 8'h05, conf_code = 8'h18;
	logic busy, m_hv, rsp_done, rsp_failed, rsp_concat, rsp_frag, rsp_phs;
	logic msg_done, kbad, auth_valid, aerr, derr, h_hv, rsp_busy;
	logic [7:0] caps [0:NUM_SUBS-1];
	logic [11:0] caps_seen;
	logic [7:0] h_ver, h_sa, h_sid, h_tps, h_eqt, kseq, auth_data;
	logic [7:0] m_hd, h_hd;
	logic [23:0] oui, hsm = 0, hsh = 0;
	row_s row;
	logic z, hit, ok;
	int err_count = 0, check_count = 0, hm = 0, hh = 0, acnt = 0;

	always #4 clk = ~clk;
	tlv_link_if tlv_link_if_i ();
	modem_tlv_end modem_tlv_end_i (.clk, .rst, .link(tlv_link_if_i.modem_end),
		.start, .kind, .concat_req, .frag_req, .phs_req, .version,
		.privacy_level, .ds_sa_count, .us_sid_count, .taps_per_sym, .eq_taps,
		.dcc_support, .mcast_support, .filter_bits, .mac_addr, .key_seq,
		.privacy_en, .auth_en, .auth_len, .auth_bytes, .digest, .digest_valid,
		.busy, .hash_data(m_hd), .hash_valid(m_hv), .rsp_done, .rsp_failed,
		.rsp_concat, .rsp_frag, .rsp_phs);
	headend_tlv_end headend_tlv_end_i (.clk, .rst,
		.link(tlv_link_if_i.headend_end), .privacy_en, .msg_done,
		.msg_kind(got_kind), .caps, .caps_seen, .version(h_ver),
		.ds_sa_count(h_sa), .us_sid_count(h_sid), .taps_per_sym(h_tps),
		.eq_taps(h_eqt), .vendor_oui(oui), .key_seq(kseq), .key_seq_bad(kbad),
		.auth_data, .auth_valid, .auth_error(aerr), .digest(dig),
		.digest_error(derr), .hash_data(h_hd), .hash_valid(h_hv), .rsp_start,
		.grant_concat, .grant_frag, .grant_phs, .refuse, .class_id, .obj_type,
		.conf_code, .rsp_busy);
	tlv_link_properties tlv_link_properties_i (.clk, .rst,
		.up_valid(tlv_link_if_i.up_valid), .up_ready(tlv_link_if_i.up_ready),
		.up_data(tlv_link_if_i.up_data), .up_last(tlv_link_if_i.up_last),
		.up_kind(tlv_link_if_i.up_kind), .dn_valid(tlv_link_if_i.dn_valid),
		.dn_ready(tlv_link_if_i.dn_ready), .dn_data(tlv_link_if_i.dn_data),
		.dn_last(tlv_link_if_i.dn_last));

	always @(posedge clk) begin
		if (m_hv === 1'b1) begin
			hm++;
			hsm = {hsm[15:0], m_hd};
		end
		if (h_hv === 1'b1) begin
			hh++;
			hsh = {hsh[15:0], h_hd};
		end
		if (auth_valid === 1'b1) begin
			acnt++;
			ash = {ash[23:0], auth_data};
		end
	end

	////////////////////////////////////////////////////////////////////////
	task chk(input logic good, input string msg);
		check_count++;
		if (good !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task await(input logic sel, output logic got);
		got = 1'b0;
		for (int i = 0; i < 300 && !got; i++) begin
			tick(1);
			got = sel ? rsp_done === 1'b1 : msg_done === 1'b1;
		end
	endtask
	task send(input msg_kind_e k);
		for (int i = 0; i < 50 && busy !== 1'b0; i++) tick(1);
		kind = k;
		start = 1'b1;
		tick(1);
		start = 1'b0;
	endtask
	task give_verdict;
		if (err_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		give_verdict;
	end

	initial begin
		tick(16);
		rst = 1'b0;
		foreach (ROWS[r]) begin
			row = ROWS[r];
			z = row.zero;
			{concat_req, frag_req, phs_req} = row.req;
			{grant_concat, grant_frag, grant_phs} = row.grant;
			refuse = row.refuse;
			version = {7'h0, !z};
			privacy_level = {7'h0, !z};
			ds_sa_count = z ? 8'h00 : 8'h03;
			us_sid_count = z ? 8'h00 : 8'h04;
			taps_per_sym = z ? 8'h00 : 8'h02;
			eq_taps = z ? 8'h00 : 8'h20;
			{dcc_support, mcast_support} = {!z, !z};
			filter_bits = z ? 2'b01 : 2'b10;
			mac_addr = {8'(r), 40'hC0FFEE1234};
			key_seq = z ? 4'h0 : 4'hF;
			auth_len = z ? 3'd1 : 3'd4;
			auth_bytes = 32'hA1B2C3D4 ^ 32'(r);
			digest = {20{8'h5A + 8'(r)}};
			{hm, hh, acnt, ash, hsm, hsh} = '0;
			send(row.kind);
			await(1'b0, hit);
			chk(hit && caps_seen === row.seen && got_kind === row.kind, "parse");
			if (row.kind == K_REG_REQ || row.kind == K_DHCP) begin
				ok = caps[0] === {7'h0, row.req[2]} && caps[2] === {7'h0, row.req[1]};
				chk(ok && caps[3] === {7'h0, row.req[0]}, "flags");
				chk(h_sa === (z ? 1 : 3) && h_sid === (z ? 1 : 4), "counts");
				chk(h_tps === (z ? 1 : 2) && h_eqt === (z ? 8 : 32), "taps");
				ok = caps[11] === {7'h0, !z} && caps[5] === {7'h0, !z};
				chk(ok && h_ver === {7'h0, !z}, "levels");
			end
			if (row.kind == K_REG_REQ) begin
				chk(oui === mac_addr[47:24], "vendor id");
				rsp_start = 1'b1;
				tick(1);
				rsp_start = 1'b0;
				await(1'b1, hit);
				ok = {rsp_concat, rsp_frag, rsp_phs} === row.rsp;
				chk(hit && ok && rsp_failed === row.refuse, "grants");
			end
			if (row.kind == K_DHCP) begin
				ok = caps[4] === 8'h01 && caps[8] === {6'h0, filter_bits};
				chk(ok, "dhcp only capabilities");
			end
			if (row.kind == K_SVC_ADD_REQ || row.kind == K_SVC_CHG_REQ) begin
				ok = ash === (z ? {24'h0, auth_bytes[31:24]} : auth_bytes);
				chk(ok && acnt == (z ? 1 : 4) && aerr === 1'b0, "auth");
				chk(kseq === (z ? 8'h00 : 8'h0F) && kbad === 1'b0, "key");
				chk(dig === digest && derr === 1'b0, "digest");
				chk(hm == (z ? 6 : 9) && hh == hm, "hash cover");
				ok = hsm === {T_KEY_SEQ, LEN_ONE, 4'h0, key_seq};
				chk(ok && hsh === hsm, "hash bytes");
			end
		end
		// digest held back: sending must wait, then finish intact
		digest_valid = 1'b0;
		send(K_SVC_CHG_REQ);
		tick(40);
		chk(busy === 1'b1 && msg_done === 1'b0, "digest wait");
		digest_valid = 1'b1;
		await(1'b0, hit);
		chk(hit && dig === digest && derr === 1'b0, "digest late");
		// privacy off: no digest element, every parameter byte hashed
		{hm, hh} = '0;
		privacy_en = 1'b0;
		send(K_SVC_ADD_REQ);
		await(1'b0, hit);
		tick(1);
		chk(hit && derr === 1'b0 && hm == 6 && hh == 6, "no digest");
		privacy_en = 1'b1;
		// reset in mid-message, then a clean registration
		send(K_DHCP);
		tick(4);
		rst = 1'b1;
		tick(2);
		ok = tlv_link_if_i.up_valid === 1'b0 && busy === 1'b0;
		chk(ok && rsp_busy === 1'b0 && msg_done === 1'b0, "reset idle");
		rst = 1'b0;
		send(K_REG_REQ);
		await(1'b0, hit);
		chk(hit && caps_seen === 12'h8EF, "after reset");
		give_verdict;
	end
endmodule // modem_capability_tlv_codec_tb
